// ===== hw/swc_pkg.sv
// Purpose: shared constants of the sleep and wake controller
// Assumes: 50 MHz reference clock, one clock domain
// Notes: register offsets are word indices on the plain register port
package swc_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 20;
  // crystal start-up wait counted in oscillator periods, oscillator taken as ref clock
  localparam int OST_OSC_PERIODS = 1024;
  localparam int OST_CYC = OST_OSC_PERIODS;
  // extra settling after low-power regulator sleep
  localparam int REG_STAB_NS = 5000;
  localparam int REG_STAB_CYC = (REG_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 11;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_REGCTL = 2'h1;
  localparam logic [1:0] ADDR_CONFIG = 2'h2;
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam int REGCTL_PM_BIT = 1;
  localparam int REGCTL_RSV_BIT = 0;
  localparam int CONFIG_WDTSLP_BIT = 0;
  localparam int CONFIG_XTAL_BIT = 1;
  localparam logic REGCTL_PM_RST = 1'b0;
  localparam logic REGCTL_RSV_RST = 1'b1;
  localparam logic CONFIG_WDTSLP_RST = 1'b0;
  localparam logic CONFIG_XTAL_RST = 1'b0;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  // ***************************************************
  // core interface codes
  // ***************************************************
  localparam int IRQ_W = 8;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;
  localparam logic [1:0] T1_SRC_FOSC = 2'h0;
  localparam logic [1:0] T1_SRC_LFOSC = 2'h1;
  localparam logic [1:0] T1_SRC_EXT = 2'h2;
  localparam logic [1:0] T1_SRC_SOSC = 2'h3;
  typedef enum {
    ST_RUN, ST_SLEEP, ST_OST, ST_REGWAIT, ST_EXEC, ST_NOP1, ST_NOP2
  } swc_state_t;
endpackage

// ===== hw/swc_delay.sv
// Purpose: loadable down-counter for wake-up waits
// Assumes: load and count come from logic on the same clock
// Notes: done pulses one cycle when a loaded count runs out
`timescale 1ns/100ps
`default_nettype none
module swc_delay
  import swc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [DLY_W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [DLY_W-1:0] remain;

  // a new load restarts the count, so a waiting state may chain two waits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      remain <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o) begin
      remain <= remain - 1'b1;
      done_o <= (remain == {{(DLY_W-1){1'b0}}, 1'b1});
      busy_o <= (remain != {{(DLY_W-1){1'b0}}, 1'b1});
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/swc_sleep_wake_controller.sv
// Purpose: power-down entry, wake-up sequencing and status flags
// Assumes: core pulses sleep_exec_i one cycle per sleep instruction
// Notes: reset pins pass a two-stage synchroniser; irq inputs are same-clock
//
// How it works
// R1: power-down is entered only on the sleep instruction pulse.
// R2: entering sleep clears watchdog; it keeps counting if enabled in sleep.
// R3: entering sleep clears powerdown_flag and sets timeout_flag.
// R4: cpu clock enable is low while asleep.
// R5: low-frequency oscillator run enable stays high during sleep.
// R6: timer one runs asleep when clocked from lf osc, ext pin or secondary osc.
// R7: adc keeps running asleep when using its dedicated rc oscillator.
// R8: io hold is asserted through sleep so pins keep their drive.
// R9: non-watchdog resets act the same awake or asleep.
// R10: wake on master clear, brownout, power-on, watchdog or enabled interrupts.
// R11: pin, brownout, power-on resets restart; watchdog and interrupts resume.
// R12: sleep execution requests prefetch of the next instruction.
// R13: interrupt wakes need individual enable, regardless of global enable.
// R14: interrupt wake with global enable clear resumes in line.
// R15: with global enable set, run prefetched instruction then vector to 0004h.
// R16: watchdog is cleared on every wake.
// R17: pending enabled irq with global enable clear makes sleep a no-op.
// R18: irq pending during or after sleep completes sleep then wakes at once.
// R19: crystal mode waits 1024 oscillator periods before resuming.
// R20: low-power regulator state while asleep when select bit is set.
// R21: low-power regulator sleep adds a stabilisation wait on wake.
// R22: intolerant peripheral enabled keeps regulator in normal mode.
// R23: the interrupt vector fetch comes in the second of two forced no-op cycles.
`timescale 1ns/100ps
`default_nettype none
module swc_sleep_wake_controller
  import swc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sleep_exec_i,
  input wire logic [IRQ_W-1:0] irq_flags_i,
  input wire logic [IRQ_W-1:0] irq_enables_i,
  input wire logic global_irq_enable_i,
  input wire logic wdt_enable_i,
  input wire logic wdt_timeout_i,
  input wire logic master_clear_pin_n_i,
  input wire logic master_clear_pin_enable_i,
  input wire logic brownout_reset_i,
  input wire logic bor_enable_i,
  input wire logic power_on_reset_i,
  input wire logic [1:0] t1_clk_sel_i,
  input wire logic adc_uses_rc_osc_i,
  input wire logic lp_intolerant_periph_i,
  output logic cpu_clk_en_o,
  output logic prefetch_next_o,
  output logic wdt_clear_o,
  output logic wdt_run_o,
  output logic device_reset_o,
  output logic resume_o,
  output logic forced_nop_o,
  output logic vector_call_o,
  output logic [15:0] vector_addr_o,
  output logic io_hold_o,
  output logic lf_osc_run_o,
  output logic timer1_run_o,
  output logic adc_run_o,
  output logic reg_lowpower_o
);
  // ***************************************************
  // declarations
  // ***************************************************
  swc_state_t state, next_state;
  logic powerdown_flag, timeout_flag;
  logic regulator_sleep_power_select, regctl_reserved;
  logic wdt_sleep_enable, xtal_mode;
  logic [1:0] master_clear_pin_sync, bor_sync, por_sync;
  logic rst_evt, irq_pend, sleep_nop, sleep_go, wake_evt, wake_is_irq;
  logic irq_woke, lp_slept;
  logic dly_load, dly_done, dly_busy;
  logic [DLY_W-1:0] dly_count;

  // true when any individually enabled interrupt flag is set
  function automatic logic any_enabled(input logic [IRQ_W-1:0] f, input logic [IRQ_W-1:0] e);
    any_enabled = |(f & e);
  endfunction

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  // stage 0 only feeds stage 1; logic reads stage 1 alone
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      master_clear_pin_sync <= 2'h3;
      bor_sync <= 2'h0;
      por_sync <= 2'h0;
    end else begin
      master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin_n_i};
      bor_sync <= {bor_sync[0], brownout_reset_i};
      por_sync <= {por_sync[0], power_on_reset_i};
    end
  end

  // reset sources look the same whatever the power state
  assign rst_evt = (!master_clear_pin_sync[1] && master_clear_pin_enable_i) || (bor_sync[1] && bor_enable_i)
                   || por_sync[1]; // see R9
  assign irq_pend = any_enabled(irq_flags_i, irq_enables_i); // see R13
  assign sleep_nop = sleep_exec_i && irq_pend && !global_irq_enable_i; // see R17
  assign sleep_go = (state == ST_RUN) && sleep_exec_i && !sleep_nop && !rst_evt; // see R1
  assign wake_is_irq = irq_pend; // see R18
  assign wake_evt = (state == ST_SLEEP) && (wake_is_irq || wdt_timeout_i); // see R10

  // ***************************************************
  // sequencer
  // ***************************************************
  // next state and wait loads; a reset event beats every other transition
  always_comb begin
    next_state = state;
    dly_load = 1'b0;
    dly_count = '0;
    case (state)
      ST_RUN: next_state = sleep_go ? ST_SLEEP : ST_RUN; // see R1
      ST_SLEEP: begin
        if (wake_evt) begin
          if (xtal_mode) begin
            next_state = ST_OST; // see R19
            dly_load = 1'b1;
            dly_count = DLY_W'(OST_CYC);
          end else if (lp_slept) begin
            next_state = ST_REGWAIT; // see R21
            dly_load = 1'b1;
            dly_count = DLY_W'(REG_STAB_CYC);
          end else if (wake_is_irq && global_irq_enable_i) begin
            next_state = ST_EXEC; // see R15
          end else begin
            next_state = ST_RUN; // see R14
          end
        end
      end
      ST_OST: begin
        if (dly_done) begin
          if (lp_slept) begin
            next_state = ST_REGWAIT; // see R21
            dly_load = 1'b1;
            dly_count = DLY_W'(REG_STAB_CYC);
          end else if (irq_woke && global_irq_enable_i) begin
            next_state = ST_EXEC;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_REGWAIT: if (dly_done) begin
        next_state = (irq_woke && global_irq_enable_i) ? ST_EXEC : ST_RUN;
      end
      ST_EXEC: next_state = ST_NOP1; // see R15
      ST_NOP1: next_state = ST_NOP2; // see R23
      ST_NOP2: next_state = ST_RUN; // see R23
      default: next_state = ST_RUN;
    endcase
    if (rst_evt) begin
      next_state = ST_RUN; // see R11
      dly_load = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // wake cause and regulator mode are caught for the later waits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_woke <= 1'b0;
      lp_slept <= 1'b0;
    end else begin
      if (wake_evt) begin
        irq_woke <= wake_is_irq;
      end
      if (sleep_go) begin
        lp_slept <= regulator_sleep_power_select && !lp_intolerant_periph_i; // see R22
      end
    end
  end

  swc_delay u_delay (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .load_i(dly_load),
    .count_i(dly_count),
    .busy_o(dly_busy),
    .done_o(dly_done)
  );

  // ***************************************************
  // status flags
  // ***************************************************
  // a no-op sleep leaves both flags alone; power-on restores both to one
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || por_sync[1]) begin
      powerdown_flag <= PD_RST;
      timeout_flag <= TO_RST;
    end else if (sleep_go) begin
      powerdown_flag <= 1'b0; // see R3
      timeout_flag <= 1'b1; // see R3
    end else if (wdt_timeout_i && (state == ST_SLEEP || state == ST_RUN)) begin
      timeout_flag <= 1'b0;
    end
  end

  // ***************************************************
  // register port
  // ***************************************************
  // status is read-only; reserved regulator bit keeps its written value
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      regulator_sleep_power_select <= REGCTL_PM_RST;
      regctl_reserved <= REGCTL_RSV_RST;
      wdt_sleep_enable <= CONFIG_WDTSLP_RST;
      xtal_mode <= CONFIG_XTAL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_REGCTL) begin
        regulator_sleep_power_select <= reg_wdata_i[REGCTL_PM_BIT];
        regctl_reserved <= reg_wdata_i[REGCTL_RSV_BIT];
      end
      if (reg_addr_i == ADDR_CONFIG) begin
        wdt_sleep_enable <= reg_wdata_i[CONFIG_WDTSLP_BIT];
        xtal_mode <= reg_wdata_i[CONFIG_XTAL_BIT];
      end
    end
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 8'h00;
      case (reg_addr_i)
        ADDR_STATUS: begin
          reg_rdata_o[STATUS_TO_BIT] <= timeout_flag;
          reg_rdata_o[STATUS_PD_BIT] <= powerdown_flag;
        end
        ADDR_REGCTL: begin
          reg_rdata_o[REGCTL_PM_BIT] <= regulator_sleep_power_select;
          reg_rdata_o[REGCTL_RSV_BIT] <= regctl_reserved;
        end
        ADDR_CONFIG: begin
          reg_rdata_o[CONFIG_WDTSLP_BIT] <= wdt_sleep_enable;
          reg_rdata_o[CONFIG_XTAL_BIT] <= xtal_mode;
        end
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ***************************************************
  // outputs toward core and clock domains
  // ***************************************************
  // outputs other than the constant vector address are registered from the next state so they line up with it
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cpu_clk_en_o <= 1'b1;
      io_hold_o <= 1'b0;
      forced_nop_o <= 1'b0;
      vector_call_o <= 1'b0;
      vector_addr_o <= 16'h0000;
      reg_lowpower_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= (next_state == ST_RUN) || (next_state == ST_EXEC)
                      || (next_state == ST_NOP1) || (next_state == ST_NOP2); // see R4
      io_hold_o <= (next_state == ST_SLEEP) || (next_state == ST_OST)
                   || (next_state == ST_REGWAIT); // see R8
      forced_nop_o <= (next_state == ST_NOP1) || (next_state == ST_NOP2); // see R23
      vector_call_o <= (next_state == ST_NOP2); // see R15
      vector_addr_o <= IRQ_VECTOR;
      reg_lowpower_o <= (next_state == ST_SLEEP) && regulator_sleep_power_select
                        && !lp_intolerant_periph_i; // see R20 see R22
    end
  end

  // event pulses toward the core and watchdog
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prefetch_next_o <= 1'b0;
      wdt_clear_o <= 1'b0;
      device_reset_o <= 1'b0;
      resume_o <= 1'b0;
    end else begin
      prefetch_next_o <= sleep_go; // see R12
      wdt_clear_o <= sleep_go || wake_evt; // see R2 see R16
      device_reset_o <= rst_evt || (state == ST_RUN && wdt_timeout_i); // see R11
      resume_o <= (state != ST_RUN) && (state != ST_EXEC) && (state != ST_NOP1)
                  && (state != ST_NOP2) && (next_state == ST_RUN || next_state == ST_EXEC)
                  && !rst_evt; // see R11
    end
  end

  // always-on domains; timer one and adc keep their clocks only from sleep-safe sources
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lf_osc_run_o <= 1'b1;
      timer1_run_o <= 1'b1;
      adc_run_o <= 1'b1;
      wdt_run_o <= 1'b0;
    end else begin
      lf_osc_run_o <= 1'b1; // see R5
      timer1_run_o <= !io_hold_o || (t1_clk_sel_i != T1_SRC_FOSC); // see R6
      adc_run_o <= !io_hold_o || adc_uses_rc_osc_i; // see R7
      wdt_run_o <= wdt_enable_i && (!io_hold_o || wdt_sleep_enable); // see R2
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  a_sleep_only_on_instr: assert property ( // see R1
    @(posedge ref_clk_i) disable iff (reset_i)
    (state == ST_RUN && next_state == ST_SLEEP) |-> sleep_exec_i)
    else $error("sleep entered without sleep instruction");
  a_entry_flags: assert property ( // see R3
    @(posedge ref_clk_i) disable iff (reset_i)
    (sleep_go && !por_sync[1]) |=> (!powerdown_flag && timeout_flag && wdt_clear_o))
    else $error("sleep entry did not update flags or clear watchdog");
  a_cpu_clock_off: assert property ( // see R4
    @(posedge ref_clk_i) disable iff (reset_i)
    (state == ST_SLEEP) |-> !cpu_clk_en_o)
    else $error("cpu clock running while asleep");
  a_nop_sleep_quiet: assert property ( // see R17
    @(posedge ref_clk_i) disable iff (reset_i)
    (state == ST_RUN && sleep_nop && !rst_evt && !wdt_timeout_i)
    |=> ($stable(powerdown_flag) && state == ST_RUN && !wdt_clear_o))
    else $error("no-op sleep changed state or flags");
  a_wake_clears_wdt: assert property ( // see R16
    @(posedge ref_clk_i) disable iff (reset_i)
    wake_evt |=> wdt_clear_o)
    else $error("wake without watchdog clear");
  a_vector_sequence: assert property ( // see R23
    @(posedge ref_clk_i) disable iff (reset_i)
    (state == ST_EXEC && !rst_evt) ##1 !rst_evt |-> ##1 (forced_nop_o && vector_call_o)
    ##1 (!forced_nop_o && !vector_call_o))
    else $error("forced no-op and vector fetch out of order");
  a_inline_resume: assert property ( // see R14
    @(posedge ref_clk_i) disable iff (reset_i)
    (wake_evt && !global_irq_enable_i && !xtal_mode && !lp_slept && !rst_evt)
    |=> (state == ST_RUN) ##1 !vector_call_o)
    else $error("global-disabled wake did not resume in line");
  a_ost_length: assert property ( // see R19
    @(posedge ref_clk_i) disable iff (reset_i)
    (state == ST_SLEEP && next_state == ST_OST) |=> (state == ST_OST) [*8])
    else $error("crystal wait ended too early");
  a_reset_restart: assert property ( // see R11
    @(posedge ref_clk_i) disable iff (reset_i)
    rst_evt |=> (device_reset_o && state == ST_RUN))
    else $error("reset event did not restart");
  a_regulator_normal: assert property ( // see R22
    @(posedge ref_clk_i) disable iff (reset_i)
    $past(lp_intolerant_periph_i) |-> !reg_lowpower_o)
    else $error("low-power regulator with intolerant peripheral");
endmodule
`default_nettype wire

// ===== tb/swc_core_model.sv
// Purpose: behavioural core and interrupt source facing the controller
// Assumes: same clock as the controller
// Notes: flags follow the bench request one cycle later, enables not applied
`timescale 1ns/100ps
`default_nettype none
module swc_core_model
  import swc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic go_sleep_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic cpu_clk_en_i,
  output logic sleep_exec_o,
  output logic [IRQ_W-1:0] irq_flags_o
);
  // ***************************************************
  // core side
  // ***************************************************
  // a gated core fetches nothing, so sleep only issues while clocked
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sleep_exec_o <= 1'b0;
    end else begin
      sleep_exec_o <= go_sleep_i & cpu_clk_en_i;
    end
  end
  // sources raise flags whatever their enables say
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_flags_o <= '0;
    end else begin
      irq_flags_o <= irq_req_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the sleep and wake controller
// Assumes: core model issues sleep and raises interrupt flags
// Notes: long wake waits are accepted within a four cycle window
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import swc_pkg::*;
  typedef struct {logic [1:0] k; logic [15:0] v;} swc_note_t;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] addr = '0, t1sel = '0;
  logic [7:0] wdata = '0, irq_req = '0, irq_en = '0, rdata, flags;
  logic wr = 0, rd = 0, rd_q = 0, go = 0, global_irq_enable = 0, wdt_to = 0, master_clear_pin_n = 1, bor = 0, por = 0;
  logic adc_rc = 0, lp_int = 0, sx, clk_en, pf, wclr, wrun, drst, drst_q = 0, res, nop, vec;
  logic hold, lf, t1run, adcrun, lowp;
  logic master_clear_pin_en = 1, bor_en = 1, wdt_en = 1;
  logic [15:0] vaddr;
  swc_note_t notes[$];
  string kn[4] = '{"rdata", "resume", "vector", "reset"};
  int errors = 0, n_compared = 0, n, d;
  int n_pf = 0, n_wclr = 0, n_nop = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

  swc_core_model CORE (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .go_sleep_i(go),
    .irq_req_i(irq_req), .cpu_clk_en_i(clk_en), .sleep_exec_o(sx), .irq_flags_o(flags));
  swc_sleep_wake_controller DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sleep_exec_i(sx),
    .irq_flags_i(flags), .irq_enables_i(irq_en), .global_irq_enable_i(global_irq_enable), .wdt_enable_i(wdt_en),
    .wdt_timeout_i(wdt_to), .master_clear_pin_n_i(master_clear_pin_n), .master_clear_pin_enable_i(master_clear_pin_en),
    .brownout_reset_i(bor), .bor_enable_i(bor_en), .power_on_reset_i(por),
    .t1_clk_sel_i(t1sel), .adc_uses_rc_osc_i(adc_rc), .lp_intolerant_periph_i(lp_int),
    .cpu_clk_en_o(clk_en), .prefetch_next_o(pf), .wdt_clear_o(wclr), .wdt_run_o(wrun),
    .device_reset_o(drst), .resume_o(res), .forced_nop_o(nop), .vector_call_o(vec),
    .vector_addr_o(vaddr), .io_hold_o(hold), .lf_osc_run_o(lf), .timer1_run_o(t1run),
    .adc_run_o(adcrun), .reg_lowpower_o(lowp));

  // ***************************************************
  // checking
  // ***************************************************
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // each result seen takes the oldest note; a result with no note is a fault
  task automatic take(input logic [1:0] k, input logic [15:0] v);
    swc_note_t t;
    if (notes.size() == 0) begin
      chk({kn[k], " unnoted"}, 16'hFFFF, v);
    end else begin
      t = notes.pop_front();
      chk(kn[k], {14'h0000, t.k}, {14'h0000, k});
      chk(kn[k], t.v, v);
    end
  endtask
  always @(posedge ref_clk_i) rd_q <= rd;
  // outputs are settled at the falling edge
  always @(negedge ref_clk_i) begin
    drst_q <= drst;
    if (rd_q) take(2'd0, {8'h00, rdata});
    if (res === 1'b1) take(2'd1, 16'h0000);
    if (vec === 1'b1) take(2'd2, vaddr);
    if (drst === 1'b1 && drst_q !== 1'b1) take(2'd3, 16'h0000);
    if (pf === 1'b1) n_pf++;
    if (wclr === 1'b1) n_wclr++;
    if (nop === 1'b1) n_nop++;
  end

  // ***************************************************
  // stimulus
  // ***************************************************
  function automatic logic [7:0] st(input logic t, input logic p);
    return (8'(t) << STATUS_TO_BIT) | (8'(p) << STATUS_PD_BIT);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    notes.push_back('{2'd0, {8'h00, e}});
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
  endtask
  task automatic do_sleep();
    @(posedge ref_clk_i);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    tick(3);
  endtask
  // bounded wait for the core clock to reach a level, cycles counted
  task automatic wait_en(input logic v, input int lim, output int c);
    c = 0;
    while (clk_en !== v) begin
      tick(1);
      c++;
      if (c > lim) begin
        chk("cpu_clk_en wait", 16'(v), 16'(clk_en));
        stop_test();
      end
    end
  endtask
  task automatic wake(input logic [7:0] src);
    @(posedge ref_clk_i);
    irq_req <= src;
    wait_en(1'b1, 1400, n);
    tick(6);
    @(posedge ref_clk_i);
    irq_req <= '0;
  endtask

  initial begin
    void'($urandom(13836));
    tick(20);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wreg(ADDR_STATUS, 8'h00);
    wreg(2'h3, 8'($urandom));
    rreg(ADDR_STATUS, st(1, 1));
    rreg(ADDR_REGCTL, 8'h01);
    rreg(ADDR_CONFIG, 8'h00);
    rreg(2'h3, 8'h00);
    $display("test registers done");
    // pending enabled flag with global enable clear turns sleep into a no-op
    irq_en <= 8'h01 << $urandom_range(0, IRQ_W - 1);
    @(posedge ref_clk_i);
    irq_req <= irq_en;
    do_sleep();
    chk("cpu_clk_en", 1, clk_en);
    rreg(ADDR_STATUS, st(1, 1));
    wake(8'h00);
    $display("test sleep no-op done");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      t1sel <= 2'(i);
      adc_rc <= i[0];
      global_irq_enable <= i[0];
      do_sleep();
      chk("cpu_clk_en", 0, clk_en);
      chk("io_hold", 1, hold);
      chk("lf_osc_run", 1, lf);
      chk("timer1_run", 16'(i != 0), t1run);
      chk("adc_run", 16'(i[0]), adcrun);
      chk("wdt_run", 0, wrun);
      rreg(ADDR_STATUS, st(1, 0));
      @(posedge ref_clk_i);
      irq_req <= ~irq_en;
      tick(6);
      chk("cpu_clk_en", 0, clk_en);
      notes.push_back('{2'd1, 16'h0000});
      if (i[0]) notes.push_back('{2'd2, IRQ_VECTOR});
      wake(irq_en);
    end
    chk("prefetch_pulses", 4, 16'(n_pf));
    chk("wdt_clear_pulses", 8, 16'(n_wclr));
    chk("forced_nop_cycles", 4, 16'(n_nop));
    $display("test interrupt wake done");
    wreg(ADDR_CONFIG, 8'h01);
    do_sleep();
    chk("wdt_run", 1, wrun);
    notes.push_back('{2'd1, 16'h0000});
    @(posedge ref_clk_i);
    wdt_to <= 1'b1;
    @(posedge ref_clk_i);
    wdt_to <= 1'b0;
    wait_en(1'b1, 20, n);
    $display("test watchdog wake done");
    for (int j = 0; j < 3; j++) begin
      wreg(ADDR_CONFIG, j == 0 ? 8'h02 : 8'h00);
      wreg(ADDR_REGCTL, j == 0 ? 8'h01 : 8'h03);
      lp_int <= (j == 2);
      do_sleep();
      chk("reg_lowpower", 16'(j == 1), lowp);
      d = (j == 0 ? OST_CYC : 0) + (j == 1 ? REG_STAB_CYC : 0);
      notes.push_back('{2'd1, 16'h0000});
      notes.push_back('{2'd2, IRQ_VECTOR});
      wake(irq_en);
      chk("wake_delay_in_window", 1, 16'(n >= d && n <= d + 4));
    end
    $display("test wake delays done");
    // disabled pin and brownout resets must neither wake nor restart a sleeping core
    master_clear_pin_en <= 1'b0;
    bor_en <= 1'b0;
    wdt_en <= 1'b0;
    tick(2);
    chk("wdt_run", 0, wrun);
    do_sleep();
    @(posedge ref_clk_i);
    master_clear_pin_n <= 1'b0;
    bor <= 1'b1;
    tick(6);
    chk("cpu_clk_en", 0, clk_en);
    @(posedge ref_clk_i);
    master_clear_pin_n <= 1'b1;
    bor <= 1'b0;
    notes.push_back('{2'd1, 16'h0000});
    notes.push_back('{2'd2, IRQ_VECTOR});
    wake(irq_en);
    master_clear_pin_en <= 1'b1;
    bor_en <= 1'b1;
    $display("test disabled resets done");
    for (int k = 0; k < 3; k++) begin
      if (k != 2) do_sleep();
      notes.push_back('{2'd3, 16'h0000});
      @(posedge ref_clk_i);
      master_clear_pin_n <= (k != 0);
      bor <= (k == 1);
      por <= (k == 2);
      tick(4);
      @(posedge ref_clk_i);
      master_clear_pin_n <= 1'b1;
      bor <= 1'b0;
      por <= 1'b0;
      wait_en(1'b1, 20, n);
      tick(4);
    end
    rreg(ADDR_STATUS, st(1, 1));
    tick(6);
    chk("pending_notes", 0, 16'(notes.size()));
    $display("test reset wakes done");
    stop_test();
  end
endmodule
`default_nettype wire
